// *** logic/fcg_map.svh ***
// Purpose: constants for the test frame generator and link monitor
// Assumes: 32-bit words on the transmit and receive streams
// Notes:   guarded header, definitions only
`ifndef FCG_MAP_SVH
`define FCG_MAP_SVH
`define FCG_DELIM_BYTES   4
`define FCG_HDR_WORDS     6
`define FCG_MAX_PAY_BYTES 2112
`define FCG_SEQ_ID_RST    8'h00
`define FCG_XID_RST       16'h0000
`define FCG_CRC_INIT      32'hFFFFFFFF
`define FCG_CRC_POLY      32'h04C11DB7
`define FCG_SOF_WORD      32'hBCB53737
`define FCG_EOF_WORD      32'hBC95D5D5
`define FCG_R_CTL         8'h00
`define FCG_TYPE          8'h00
`define FCG_F_CTL         24'h380000
`define FCG_FOX_LEN       55
`define FCG_PRBS9_LEN     511
`define FCG_CLK_HZ        50000000
`endif

// *** logic/fcg_pkg.sv ***
// Purpose: types for the test frame generator and link monitor
// Assumes: nothing beyond the map header
// Notes:   one-hot transmit states
package fcg_pkg;
   typedef enum logic [5:0] {
      FCG_IDLE = 6'h01,
      FCG_SOF  = 6'h02,
      FCG_HDR  = 6'h04,
      FCG_PAY  = 6'h08,
      FCG_CRC  = 6'h10,
      FCG_EOF  = 6'h20
   } fcg_tx_e;
   typedef enum logic [2:0] {
      FCG_PAT_FOX   = 3'h0,
      FCG_PAT_5555  = 3'h1,
      FCG_PAT_PRBS9 = 3'h2,
      FCG_PAT_PRBS31= 3'h3,
      FCG_PAT_USER  = 3'h4,
      FCG_PAT_ZERO  = 3'h5
   } fcg_pat_e;
endpackage

// *** logic/fcg_top.sv ***
// Purpose: test frame builder and receive link monitor for one port
// Assumes: word-wide streams, line coding done downstream
// Notes:   second port framing, pattern and originator identifier mirror first while follow is set
// How it works
// - unframed frame: start delimiter, 0..2112 payload bytes, end delimiter
// - framed frame: start, 24-byte header, payload, CRC, end delimiter
// - text pattern repeats the pangram sentence and digits as ASCII
// - pseudo-random payloads of order 9 and order 31
// - user pattern repeats a 32-bit value editable while selected
// - sequence, originator and responder identifiers programmable, rest internal
// - header is six words in the fixed field order
// - received bit rate measured continuously in bits per second
// - rate offset reported in ppm and in bits per second
// - accumulated bit difference counted, cleared on measurement start
// - signal present follows bit synchronization
// - sync indicator follows word synchronization
// - fabric login indicator after login to a fabric port
// - link parameter indicator after exchange with an expansion port
// - port login indicator after login to a node port
// - separate traffic, pattern sync and pattern error indications
// - live and latched alarm states, latched held until cleared
// - follow mode makes port two track port one framing, pattern and originator identifier
// - line code chosen: 8b/10b lower rates, 64b/66b top rate
`timescale 1ns/1ps
`include "fcg_map.svh"
module fcg_top
   import fcg_pkg::*;
#(
   parameter int NOM_RATE_BPS = 1062500000,
   parameter int GATE_CYCLES  = `FCG_CLK_HZ
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   input  wire logic        TX_START,
   input  wire logic        FRAMED,
   input  wire logic [2:0]  PATTERN,
   input  wire logic [11:0] PAY_BYTES,
   input  wire logic [31:0] USER_WORD,
   input  wire logic [7:0]  SEQ_ID,
   input  wire logic [15:0] OX_ID,
   input  wire logic [15:0] RX_ID,
   input  wire logic [2:0]  RATE_SEL,
   input  wire logic        FOLLOW,
   output logic             P2_FRAMED,
   output logic [2:0]       P2_PATTERN,
   output logic [15:0]      P2_OX_ID,
   output logic             LINE_CODE_66,
   output logic [31:0]      TX_DATA,
   output logic             TX_VALID,
   output logic             TX_SOF,
   output logic             TX_EOF,
   output logic             TX_BUSY,
   input  wire logic        RX_BIT_TICK,
   input  wire logic        RX_BIT_LOCK,
   input  wire logic        RX_WORD_LOCK,
   input  wire logic        RX_VALID,
   input  wire logic [31:0] RX_DATA,
   input  wire logic        FLOGI_DONE,
   input  wire logic        ELP_DONE,
   input  wire logic        PLOGI_DONE,
   input  wire logic        MEAS_START,
   input  wire logic        TRAP_CLEAR,
   output logic [31:0]      BIT_RATE_BPS,
   output logic [31:0]      RATE_DIFF_BPS,
   output logic [31:0]      RATE_DIFF_PPM,
   output logic [31:0]      ACCUM_DIFF_BITS,
   output logic             SIGNAL_PRESENT,
   output logic             SYNC_ACQUIRED,
   output logic             FABRIC_LOGIN,
   output logic             ELP_DONE_IND,
   output logic             PORT_LOGIN,
   output logic             TRAFFIC,
   output logic             PAT_SYNC,
   output logic             PAT_ERROR,
   output logic [2:0]       TRAP_REG
);
   // ==========================================================
   // pattern sources
   localparam logic [439:0] FOX_TEXT =
      "The quick brown fox jumped over the lazy dog 1234567890";
   fcg_tx_e     st_reg;
   logic [11:0] cnt_reg;
   logic [5:0]  fox_idx_reg;
   logic [30:0] lfsr_reg;
   logic [31:0] crc_reg;
   logic [31:0] pat_word;
   logic [31:0] hdr_word;
   logic [31:0] lfsr_word;
   logic [30:0] lfsr_next;
   logic [31:0] crc_next;
   logic [5:0]  fox_next;
   logic [11:0] pay_words;

   // advance either a 9th or 31st order generator by 32 bits
   always_comb begin
      lfsr_next = lfsr_reg;
      lfsr_word = 32'h0;
      for (int i = 0; i < 32; i++) begin
         if (PATTERN == FCG_PAT_PRBS9) begin
            lfsr_word[31-i] = lfsr_next[8];
            lfsr_next = {22'h0, lfsr_next[7:0], lfsr_next[8] ^ lfsr_next[4]};
         end else begin
            lfsr_word[31-i] = lfsr_next[30];
            lfsr_next = {lfsr_next[29:0], lfsr_next[30] ^ lfsr_next[27]};
         end
      end
   end

   // four text characters per word, wrapping over the sentence
   always_comb begin
      fox_next = 6'h00;
      pat_word = 32'h0;
      for (int b = 0; b < 4; b++) begin
         fox_next = (fox_idx_reg + 6'(b) >= 6'(`FCG_FOX_LEN)) ?
            fox_idx_reg + 6'(b) - 6'(`FCG_FOX_LEN) : fox_idx_reg + 6'(b);
         pat_word[31-8*b -: 8] = FOX_TEXT[439 - 8*fox_next -: 8];
      end
      fox_next = (fox_idx_reg + 6'h04 >= 6'(`FCG_FOX_LEN)) ?
         fox_idx_reg + 6'h04 - 6'(`FCG_FOX_LEN) : fox_idx_reg + 6'h04;
      unique case (PATTERN)
         FCG_PAT_FOX:    ;
         FCG_PAT_5555:   pat_word = 32'h55555555;
         FCG_PAT_PRBS9,
         FCG_PAT_PRBS31: pat_word = lfsr_word;
         FCG_PAT_USER:   pat_word = USER_WORD;
         default:        pat_word = 32'h0;
      endcase
   end

   // ==========================================================
   // header words, internal fields fixed
   always_comb begin
      unique case (cnt_reg[2:0])
         3'h0:    hdr_word = {`FCG_R_CTL, 24'h000001};
         3'h1:    hdr_word = {8'h00, 24'h000002};
         3'h2:    hdr_word = {`FCG_TYPE, `FCG_F_CTL};
         3'h3:    hdr_word = {SEQ_ID, 8'h00, 16'h0000};
         3'h4:    hdr_word = {OX_ID, RX_ID};
         default: hdr_word = 32'h0;
      endcase
   end

   // crc over the word leaving now
   always_comb begin
      crc_next = crc_reg;
      for (int i = 31; i >= 0; i--) begin
         crc_next = {crc_next[30:0], 1'b0} ^
            (((crc_next[31] ^ TX_DATA[i]) == 1'b1) ? `FCG_CRC_POLY : 32'h0);
      end
   end

   // payload length rounded up to whole words, capped
   assign pay_words = (PAY_BYTES > 12'(`FCG_MAX_PAY_BYTES)) ? 12'(`FCG_MAX_PAY_BYTES / 4) :
      12'((PAY_BYTES + 12'h003) >> 2);

   // ==========================================================
   // frame sequencer
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         st_reg      <= FCG_IDLE;
         cnt_reg     <= 12'h000;
         fox_idx_reg <= 6'h00;
         lfsr_reg    <= 31'h7FFFFFFF;
         crc_reg     <= `FCG_CRC_INIT;
         TX_DATA     <= 32'h0;
         TX_VALID    <= 1'b0;
         TX_SOF      <= 1'b0;
         TX_EOF      <= 1'b0;
      end else begin
         TX_SOF   <= 1'b0;
         TX_EOF   <= 1'b0;
         TX_VALID <= 1'b0;
         if (TX_VALID && (st_reg == FCG_HDR || st_reg == FCG_PAY))
            crc_reg <= crc_next;
         unique case (st_reg)
            FCG_IDLE: if (TX_START) begin
               st_reg   <= FCG_SOF;
               TX_DATA  <= `FCG_SOF_WORD;
               TX_VALID <= 1'b1;
               TX_SOF   <= 1'b1;
               crc_reg  <= `FCG_CRC_INIT;
               cnt_reg  <= 12'h000;
               // patterns restart per frame: keeps order 9 out of its all-zero lock
               fox_idx_reg <= 6'h00;
               lfsr_reg    <= 31'h7FFFFFFF;
            end
            FCG_SOF, FCG_HDR, FCG_PAY: begin
               TX_VALID <= 1'b1;
               if (st_reg == FCG_SOF && FRAMED) begin
                  st_reg  <= FCG_HDR;
                  TX_DATA <= hdr_word;
                  cnt_reg <= 12'h001;
               end else if (st_reg == FCG_HDR && cnt_reg != 12'(`FCG_HDR_WORDS)) begin
                  TX_DATA <= hdr_word;
                  cnt_reg <= cnt_reg + 12'h001;
               end else if (st_reg != FCG_PAY && pay_words != 12'h000) begin
                  st_reg  <= FCG_PAY;
                  TX_DATA <= pat_word;
                  cnt_reg <= 12'h001;
                  lfsr_reg <= lfsr_next;
                  fox_idx_reg <= fox_next;
               end else if (st_reg == FCG_PAY && cnt_reg != pay_words) begin
                  TX_DATA <= pat_word;
                  cnt_reg <= cnt_reg + 12'h001;
                  lfsr_reg <= lfsr_next;
                  fox_idx_reg <= fox_next;
               end else if (FRAMED) begin
                  st_reg  <= FCG_CRC;
                  TX_DATA <= ~crc_next;
               end else begin
                  st_reg  <= FCG_EOF;
                  TX_DATA <= `FCG_EOF_WORD;
                  TX_EOF  <= 1'b1;
               end
            end
            FCG_CRC: begin
               st_reg   <= FCG_EOF;
               TX_DATA  <= `FCG_EOF_WORD;
               TX_VALID <= 1'b1;
               TX_EOF   <= 1'b1;
            end
            FCG_EOF: st_reg <= FCG_IDLE;
         endcase
      end
   end
   assign TX_BUSY = (st_reg != FCG_IDLE);

   // line code choice: top rate select uses 64b/66b
   assign LINE_CODE_66 = (RATE_SEL == 3'h4);

   // ==========================================================
   // second port mirror
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         P2_FRAMED  <= 1'b0;
         P2_PATTERN <= 3'h0;
         P2_OX_ID   <= `FCG_XID_RST;
      end else if (FOLLOW) begin
         P2_FRAMED  <= FRAMED;
         P2_PATTERN <= PATTERN;
         P2_OX_ID   <= OX_ID;
      end
   end

   // ==========================================================
   // rate measurement over a one-second gate
   logic [31:0] gate_reg;
   logic [31:0] bits_reg;
   logic [31:0] diff;
   logic [63:0] rate_wide;
   // bits seen in one gate at exactly the nominal rate
   localparam logic [31:0] NOM_GATE_BITS =
      32'((64'(NOM_RATE_BPS) * 64'(GATE_CYCLES)) / 64'(`FCG_CLK_HZ));
   // scale the gate count to bits per second, so a short gate still reads true
   assign rate_wide = (64'(bits_reg) * 64'(`FCG_CLK_HZ)) / 64'(GATE_CYCLES);
   assign diff = BIT_RATE_BPS - 32'(NOM_RATE_BPS);
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         gate_reg        <= 32'h0;
         bits_reg        <= 32'h0;
         BIT_RATE_BPS    <= 32'h0;
         RATE_DIFF_BPS   <= 32'h0;
         RATE_DIFF_PPM   <= 32'h0;
         ACCUM_DIFF_BITS <= 32'h0;
      end else begin
         bits_reg <= bits_reg + {31'h0, RX_BIT_TICK};
         gate_reg <= gate_reg + 32'h1;
         if (MEAS_START) begin
            ACCUM_DIFF_BITS <= 32'h0;
            gate_reg <= 32'h0;
            bits_reg <= {31'h0, RX_BIT_TICK}; // first gate as long as the rest
         end else if (gate_reg == 32'(GATE_CYCLES - 1)) begin
            gate_reg      <= 32'h0;
            bits_reg      <= {31'h0, RX_BIT_TICK};
            BIT_RATE_BPS  <= rate_wide[31:0];
            RATE_DIFF_BPS <= rate_wide[31:0] - 32'(NOM_RATE_BPS);
            ACCUM_DIFF_BITS <= ACCUM_DIFF_BITS + bits_reg - NOM_GATE_BITS;
         end
         RATE_DIFF_PPM <= 32'(($signed(diff) * 64'sd1000000) / NOM_RATE_BPS);
      end
   end

   // ==========================================================
   // link state, live and trapped alarms
   logic [31:0] exp_word_reg;
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         SIGNAL_PRESENT <= 1'b0;
         SYNC_ACQUIRED  <= 1'b0;
         FABRIC_LOGIN   <= 1'b0;
         ELP_DONE_IND   <= 1'b0;
         PORT_LOGIN     <= 1'b0;
         TRAFFIC        <= 1'b0;
         PAT_SYNC       <= 1'b0;
         PAT_ERROR      <= 1'b0;
         exp_word_reg   <= 32'h0;
      end else begin
         SIGNAL_PRESENT <= RX_BIT_LOCK;
         SYNC_ACQUIRED  <= RX_WORD_LOCK;
         FABRIC_LOGIN   <= FLOGI_DONE;
         ELP_DONE_IND   <= ELP_DONE;
         PORT_LOGIN     <= PLOGI_DONE;
         TRAFFIC        <= RX_VALID;
         PAT_ERROR      <= 1'b0;
         if (RX_VALID) begin
            // self-seeding check: next word predicted to repeat the last received word
            exp_word_reg <= RX_DATA;
            PAT_SYNC  <= (RX_DATA == exp_word_reg);
            PAT_ERROR <= PAT_SYNC && (RX_DATA != exp_word_reg);
         end
         if (!RX_WORD_LOCK)
            PAT_SYNC <= 1'b0;
      end
   end

   // trapped alarms: set wins over clear
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST)
         TRAP_REG <= 3'h0;
      else
         TRAP_REG <= (TRAP_CLEAR ? 3'h0 : TRAP_REG) |
            {PAT_ERROR, ~SYNC_ACQUIRED, ~SIGNAL_PRESENT};
   end
endmodule

// *** testbench/fcg_asserts.sv ***
// Purpose: port checker for the frame builder and link monitor
// Assumes: header fields and framing held steady while a frame runs
// Notes:   bound to fcg_top, one clock domain
`timescale 1ns/1ps
module fcg_asserts (
   input wire logic        CORE_CLK,
   input wire logic        RST,
   input wire logic        TX_START,
   input wire logic        TX_BUSY,
   input wire logic        FRAMED,
   input wire logic [7:0]  SEQ_ID,
   input wire logic [15:0] OX_ID,
   input wire logic [15:0] RX_ID,
   input wire logic [2:0]  RATE_SEL,
   input wire logic        LINE_CODE_66,
   input wire logic [31:0] TX_DATA,
   input wire logic        TX_VALID,
   input wire logic        TX_SOF,
   input wire logic        TX_EOF,
   input wire logic        RX_BIT_LOCK,
   input wire logic        SIGNAL_PRESENT,
   input wire logic        RX_VALID,
   input wire logic        TRAFFIC,
   input wire logic        PAT_ERROR,
   input wire logic [2:0]  TRAP_REG,
   input wire logic        TRAP_CLEAR
);
   // ========================================
   // frame shape and status relations
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   AST_SOF_AFTER_START: assert property (TX_START && !TX_BUSY |=> TX_VALID && TX_SOF && TX_DATA == 32'hBCB53737) else $error("start not answered by start delimiter");
   AST_HDR_ORDER: assert property (TX_START && !TX_BUSY && FRAMED |-> ##2 TX_DATA == 32'h00000001 ##1 TX_DATA == 32'h00000002 ##1 TX_DATA == 32'h00380000) else $error("header words out of order");
   AST_HDR_IDS: assert property (TX_START && !TX_BUSY && FRAMED |-> ##5 TX_DATA == {SEQ_ID, 24'h000000} ##1 TX_DATA == {OX_ID, RX_ID} ##1 TX_DATA == 32'h00000000) else $error("header identifiers wrong");
   AST_EOF_ENDS: assert property (TX_EOF |-> TX_VALID && TX_DATA == 32'hBC95D5D5 ##1 !TX_VALID) else $error("end delimiter wrong");
   AST_SIGNAL_TRACKS: assert property (1'b1 |=> SIGNAL_PRESENT == $past(RX_BIT_LOCK)) else $error("signal indicator stale");
   AST_TRAFFIC_TRACKS: assert property ($rose(RX_VALID) |=> TRAFFIC ##1 (TRAFFIC == $past(RX_VALID))) else $error("traffic indicator stale");
   AST_TRAP_HOLDS: assert property (TRAP_REG != 3'h0 && !TRAP_CLEAR |=> (TRAP_REG & $past(TRAP_REG)) == $past(TRAP_REG)) else $error("trapped state lost");
   AST_ERR_TRAPPED: assert property (PAT_ERROR |-> ##[0:1] TRAP_REG[2]) else $error("pattern error not trapped");
   AST_LINE_CODE: assert property (LINE_CODE_66 == (RATE_SEL == 3'h4)) else $error("line code choice wrong");
endmodule
bind fcg_top fcg_asserts fcg_asserts_inst (.*);

// *** testbench/fcg_far_end.sv ***
// Purpose: far end port sending received words and bit ticks
// Assumes: one bit tick per cycle is full line rate
// Notes:   idle data toggles each cycle between the inverse of the last word and the word itself
`timescale 1ns/1ps
module fcg_far_end (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        half_rate,
   input  wire logic        send,
   input  wire logic [31:0] word,
   input  wire logic        corrupt,
   output logic             rx_bit_tick,
   output logic             rx_valid,
   output logic [31:0]      rx_data
);
   logic phase_reg;
   // ========================================
   // ticks at full or half rate, words on request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_reg   <= 1'b0;
         rx_bit_tick <= 1'b0;
         rx_valid    <= 1'b0;
         rx_data     <= 32'h00000000;
      end else begin
         phase_reg   <= ~phase_reg;
         rx_bit_tick <= ~half_rate | phase_reg;
         rx_valid    <= send;
         rx_data     <= send ? (corrupt ? ~word : word) : ~rx_data;
      end
   end
endmodule

// *** testbench/fcg_top_tb.sv ***
// Purpose: self-checking bench for the frame builder and link monitor
// Assumes: rate gate shortened to 100 cycles, nominal rate 50 Mb/s
// Notes:   received traffic comes from fcg_far_end
`timescale 1ns/1ps
module fcg_top_tb;
   import fcg_pkg::*;
   // ========================================
   // signals
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cyc = 0;
   logic        clk, rst, start, framed, follow, blk, wlk, flogi, elp, plogi;
   logic        meas, tclr, half, send, bad, tick, rxv, lc66, txv, sof, eof, busy;
   logic        p2f, sig, syn, fab, elpi, plog, traf, psync, perr, seen;
   logic [2:0]  pat, rsel, p2p, trap;
   logic [11:0] pay;
   logic [31:0] uw, rxw, rxd, txd, rate, dbps, dppm, acc;
   logic [7:0]  seq;
   logic [15:0] ox, rx, p2o;
   logic [31:0] q[$];
   logic [31:0] e[$];
   fcg_top #(.NOM_RATE_BPS(50000000), .GATE_CYCLES(100)) fcg_top_inst (
      .CORE_CLK(clk), .RST(rst), .TX_START(start), .FRAMED(framed), .PATTERN(pat),
      .PAY_BYTES(pay), .USER_WORD(uw), .SEQ_ID(seq), .OX_ID(ox), .RX_ID(rx),
      .RATE_SEL(rsel), .FOLLOW(follow), .P2_FRAMED(p2f), .P2_PATTERN(p2p),
      .P2_OX_ID(p2o), .LINE_CODE_66(lc66), .TX_DATA(txd), .TX_VALID(txv), .TX_SOF(sof),
      .TX_EOF(eof), .TX_BUSY(busy), .RX_BIT_TICK(tick), .RX_BIT_LOCK(blk),
      .RX_WORD_LOCK(wlk), .RX_VALID(rxv), .RX_DATA(rxd), .FLOGI_DONE(flogi),
      .ELP_DONE(elp), .PLOGI_DONE(plogi), .MEAS_START(meas), .TRAP_CLEAR(tclr),
      .BIT_RATE_BPS(rate), .RATE_DIFF_BPS(dbps), .RATE_DIFF_PPM(dppm),
      .ACCUM_DIFF_BITS(acc), .SIGNAL_PRESENT(sig), .SYNC_ACQUIRED(syn),
      .FABRIC_LOGIN(fab), .ELP_DONE_IND(elpi), .PORT_LOGIN(plog), .TRAFFIC(traf),
      .PAT_SYNC(psync), .PAT_ERROR(perr), .TRAP_REG(trap));
   fcg_far_end fcg_far_end_inst (.clk(clk), .rst(rst), .half_rate(half), .send(send),
      .word(rxw), .corrupt(bad), .rx_bit_tick(tick), .rx_valid(rxv), .rx_data(rxd));
   // 20 ns clock and a hang limit well above the longest run
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   // ========================================
   // shared tasks
   task automatic report_and_stop();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      n_compared++;
      if (got !== want) begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
   endtask
   // start one frame and gather its words up to the end delimiter
   task automatic run_frame();
      int n;
      n = 0;
      q.delete();
      @(posedge clk);
      start <= 1'b1;
      do begin
         @(posedge clk);
         start <= 1'b0;
         #1;
         if (txv === 1'b1) q.push_back(txd);
         n++;
      end while (eof !== 1'b1 && n < 3000);
      @(posedge clk);
   endtask
   function automatic logic [31:0] crc_of();
      logic [31:0] c;
      c = 32'hFFFFFFFF;
      for (int i = 1; i < 8; i++)
         for (int b = 31; b >= 0; b--)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ e[i][b]) ? 32'h04C11DB7 : 32'h00000000);
      return ~c;
   endfunction
   // payload bits that differ from the bit 511 places later
   function automatic int mism511();
      int m;
      m = 0;
      for (int i = 0; i < 16384; i++)
         if (q[1 + i / 32][31 - i % 32] !== q[1 + (i + 511) / 32][31 - (i + 511) % 32]) m++;
      return m;
   endfunction
   // ========================================
   // scenarios
   task automatic t_unframed();
      pat <= FCG_PAT_USER;
      uw <= 32'hA5C30F1E;
      pay <= 12'h008;
      run_frame();
      chk(q.size(), 32'h4);
      chk(q[0], 32'hBCB53737);
      chk(q[2], 32'hA5C30F1E);
      chk(q[3], 32'hBC95D5D5);
      uw <= 32'h3C3C0001;
      pay <= 12'h000;
      run_frame();
      chk(q.size(), 32'h2);
      pay <= 12'h004;
      run_frame();
      chk(q[1], 32'h3C3C0001);
   endtask
   task automatic t_framed();
      framed <= 1'b1;
      pat <= FCG_PAT_ZERO;
      seq <= 8'h5A;
      ox <= 16'h1234;
      rx <= 16'hABCD;
      run_frame();
      e = '{32'hBCB53737, 32'h1, 32'h2, 32'h00380000, 32'h5A000000, 32'h1234ABCD, 32'h0, 32'h0};
      e.push_back(crc_of());
      e.push_back(32'hBC95D5D5);
      chk(q.size(), 32'hA);
      for (int i = 0; i < 10; i++) chk(q[i], e[i]);
      chk({p2f, p2o}, 17'h11234);
      chk(p2p, 32'h5);
      framed <= 1'b0;
   endtask
   task automatic t_patterns();
      pat <= FCG_PAT_FOX;
      run_frame();
      chk(q[1], 32'h54686520);
      pat <= FCG_PAT_PRBS9;
      pay <= 12'h840;
      run_frame();
      chk(q.size(), 32'h212);
      chk(mism511(), 32'h0);
      chk(q[1] === q[2], 32'h0);
      pat <= FCG_PAT_PRBS31;
      run_frame();
      chk(mism511() > 0, 32'h1);
   endtask
   task automatic t_status();
      {blk, wlk, flogi, elp, plogi} <= 5'h1F;
      rsel <= 3'h4;
      repeat (3) @(posedge clk);
      #1;
      chk({sig, syn, fab, elpi, plog}, 32'h1F);
      chk({busy, lc66}, 32'h1);
      @(posedge clk);
      tclr <= 1'b1;
      {blk, wlk, flogi, elp, plogi} <= 5'h00;
      @(posedge clk);
      tclr <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk({sig, syn, fab, elpi, plog, trap[1:0]}, 32'h03);
      @(posedge clk);
      {blk, wlk} <= 2'h3;
      repeat (3) @(posedge clk);
      #1;
      chk(trap[1:0], 32'h3);
      @(posedge clk);
      tclr <= 1'b1;
      @(posedge clk);
      tclr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(trap, 32'h0);
   endtask
   task automatic t_rx_pattern();
      seen = 1'b0;
      @(posedge clk);
      rxw <= 32'hC0FFEE11;
      send <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk({traf, psync, perr}, 32'h6);
      @(posedge clk);
      bad <= 1'b1;
      @(posedge clk);
      bad <= 1'b0;
      repeat (4) @(posedge clk) #1 seen = seen | perr;
      chk({seen, trap[2]}, 32'h3);
      @(posedge clk);
      send <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(traf, 32'h0);
   endtask
   task automatic t_rate();
      @(posedge clk);
      meas <= 1'b1;
      @(posedge clk);
      meas <= 1'b0;
      repeat (250) @(posedge clk);
      #1;
      chk(rate, 32'h02FAF080);
      chk(dbps | dppm | acc, 32'h0);
      @(posedge clk);
      half <= 1'b1;
      repeat (250) @(posedge clk);
      #1;
      chk(rate, 32'h017D7840);
      chk(dbps, 32'hFE8287C0);
      chk(dppm, 32'hFFF85EE0);
      chk(acc[31], 32'h1);
      @(posedge clk);
      meas <= 1'b1;
      @(posedge clk);
      meas <= 1'b0;
      #1;
      chk(acc, 32'h0);
   endtask
   // ========================================
   // main sequence
   initial begin
      {start, framed, blk, wlk, flogi, elp, plogi, meas, tclr, half, send, bad} = '0;
      {pat, rsel, pay, uw, rxw, seq, ox, rx} = '0;
      follow = 1'b1;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_unframed();
      t_framed();
      t_patterns();
      t_status();
      t_rx_pattern();
      t_rate();
      report_and_stop();
   end
endmodule
